//--- hw/sfc_pkg.sv
// Purpose: Shared opcodes, phases, carriers and decode for the serial flash command front end.
// Assumes: Three-byte addressing, single SPI command framing.
// Notes:   Opcode framing properties live in one decode function used by both clock domains; ranges and command kinds are decoded in the front end.
package sfc_pkg;

  localparam logic [7:0] OP_SET_WL  = 8'h06;
  localparam logic [7:0] OP_CLR_WL  = 8'h04;
  localparam logic [7:0] OP_VSR_EN  = 8'h50;
  localparam logic [7:0] OP_RD_SR1  = 8'h05;
  localparam logic [7:0] OP_RD_SR2  = 8'h35;
  localparam logic [7:0] OP_RD_SR3  = 8'h15;
  localparam logic [7:0] OP_WR_SR1  = 8'h01;
  localparam logic [7:0] OP_WR_SR2  = 8'h31;
  localparam logic [7:0] OP_WR_SR3  = 8'h11;
  localparam logic [7:0] OP_READ    = 8'h03;
  localparam logic [7:0] OP_FAST    = 8'h0b;
  localparam logic [7:0] OP_DOUT    = 8'h3b;
  localparam logic [7:0] OP_QOUT    = 8'h6b;
  localparam logic [7:0] OP_DIO     = 8'hbb;
  localparam logic [7:0] OP_QIO     = 8'heb;
  localparam logic [7:0] OP_PP      = 8'h02;
  localparam logic [7:0] OP_QPP     = 8'h32;
  localparam logic [7:0] OP_SE      = 8'h20;
  localparam logic [7:0] OP_BE      = 8'hd8;
  localparam logic [7:0] OP_CE1     = 8'hc7;
  localparam logic [7:0] OP_CE2     = 8'h60;
  localparam logic [7:0] OP_RST_EN  = 8'h66;
  localparam logic [7:0] OP_RST     = 8'h99;
  localparam logic [7:0] OP_DPD     = 8'hb9;
  localparam logic [7:0] OP_RDPD    = 8'hab;
  localparam logic [7:0] OP_RDID    = 8'h9f;
  localparam logic [7:0] OP_MFID    = 8'h90;
  localparam logic [7:0] OP_SFDP    = 8'h5a;
  localparam logic [7:0] OP_RDSEC   = 8'h48;

  localparam logic [23:0] PAGE_MASK = 24'h0000ff;
  localparam logic [23:0] SECT_MASK = 24'h000fff;
  localparam logic [23:0] BLK_MASK  = 24'h00ffff;
  localparam logic [23:0] ARR_TOP   = 24'hffffff;
  localparam logic [7:0]  IDLE_BYTE = 8'hff;
  localparam int unsigned STAT_WL_BIT = 1;
  localparam int unsigned FIFO_W      = 8;
  localparam int unsigned FIFO_D      = 4;

  typedef enum logic [2:0] {
    ST_OP    = 3'h0,
    ST_ADDR  = 3'h1,
    ST_MODE  = 3'h2,
    ST_DUMMY = 3'h3,
    ST_DIN   = 3'h4,
    ST_DOUT  = 3'h5,
    ST_DONE  = 3'h6
  } sfc_st_e;

  typedef enum logic [2:0] {
    CMD_PGM      = 3'h0,
    CMD_PGM_DROP = 3'h1,
    CMD_SE       = 3'h2,
    CMD_BE       = 3'h3,
    CMD_CE       = 3'h4,
    CMD_SR_WR    = 3'h5,
    CMD_SRST     = 3'h6
  } sfc_cmd_e;

  typedef struct packed {
    logic       addr;
    logic       mode;
    logic [1:0] dummy;
    logic [2:0] in_w;
    logic [2:0] din_w;
    logic [2:0] out_w;
    logic       stat;
  } sfc_op_s;

  typedef struct packed {
    logic        valid;
    sfc_cmd_e    kind;
    logic [23:0] addr;
    logic [15:0] sr_data;
    logic [1:0]  sr_cnt;
    logic [1:0]  sr_sel;
  } sfc_cmd_s;

  typedef struct packed {
    logic        en;
    logic [23:0] lo;
    logic [23:0] hi;
  } sfc_prot_s;

  typedef struct packed {
    logic        start;
    logic [7:0]  op;
    logic [23:0] addr;
  } sfc_rd_s;

  function automatic sfc_op_s sfc_decode(input logic [7:0] op);
    sfc_op_s d;
    d = '0;
    d.in_w = 3'h1;
    unique case (op)
      OP_READ, OP_MFID: begin
        d.addr = 1'b1;
        d.out_w = 3'h1;
      end
      OP_FAST, OP_SFDP, OP_RDSEC: begin
        d.addr = 1'b1;
        d.dummy = 2'h1;
        d.out_w = 3'h1;
      end
      OP_DOUT: begin
        d.addr = 1'b1;
        d.dummy = 2'h1;
        d.out_w = 3'h2;
      end
      OP_QOUT: begin
        d.addr = 1'b1;
        d.dummy = 2'h1;
        d.out_w = 3'h4;
      end
      OP_DIO: begin
        d.addr = 1'b1;
        d.mode = 1'b1;
        d.in_w = 3'h2;
        d.out_w = 3'h2;
      end
      OP_QIO: begin
        d.addr = 1'b1;
        d.mode = 1'b1;
        d.dummy = 2'h2;
        d.in_w = 3'h4;
        d.out_w = 3'h4;
      end
      OP_RD_SR1, OP_RD_SR2, OP_RD_SR3: begin
        d.out_w = 3'h1;
        d.stat = 1'b1;
      end
      OP_RDID: d.out_w = 3'h1;
      OP_RDPD: begin
        d.dummy = 2'h3;
        d.out_w = 3'h1;
      end
      OP_PP: begin
        d.addr = 1'b1;
        d.din_w = 3'h1;
      end
      OP_QPP: begin
        d.addr = 1'b1;
        d.din_w = 3'h4;
      end
      OP_WR_SR1, OP_WR_SR2, OP_WR_SR3: d.din_w = 3'h1;
      OP_SE, OP_BE: d.addr = 1'b1;
      default: d.in_w = 3'h1;
    endcase
    return d;
  endfunction

  function automatic logic sfc_overlap(input sfc_prot_s p, input logic [23:0] lo, input logic [23:0] hi);
    return p.en && (lo <= p.hi) && (hi >= p.lo);
  endfunction

endpackage

//--- hw/sfc_frontend.sv
// Purpose: Serial flash command front end: framing, decode, read streaming, write-type execution.
// Assumes: SPI mode 0 or 3; chip select high time exceeds four core clocks.
// Notes:   Link state is held after chip select rises and sampled by the core once the rise is synced.
`timescale 1ns/1ps

module sfc_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 4
) (
  input  wire logic         i_wclk,
  input  wire logic         i_wrst_n,
  input  wire logic         i_wclr,
  input  wire logic         i_wvalid,
  input  wire logic [W-1:0] i_wdata,
  output logic              o_wready,
  input  wire logic         i_rclk,
  input  wire logic         i_rrst_n,
  input  wire logic         i_rready,
  output logic              o_rvalid,
  output logic [W-1:0]      o_rdata
);
  // D must be a power of two, at least 4, for the gray full test
  localparam int unsigned AW = $clog2(D);

  logic [W-1:0] mem_q [D];
  logic [AW:0]  wbin_q;
  logic [AW:0]  wgray_q;
  logic [AW:0]  rbin_q;
  logic [AW:0]  rgray_q;
  logic [AW:0]  rg_m_q;
  logic [AW:0]  rg_s_q;
  logic [AW:0]  wg_m_q;
  logic [AW:0]  wg_s_q;
  logic [AW:0]  wbin_n;
  logic [AW:0]  rbin_n;
  logic         push;
  logic         pop;

  assign wbin_n   = wbin_q + 1'b1;
  assign rbin_n   = rbin_q + 1'b1;
  assign o_wready = wgray_q != {~rg_s_q[AW:AW-1], rg_s_q[AW-2:0]};
  assign o_rvalid = rgray_q != wg_s_q;
  assign push     = i_wvalid & o_wready;
  assign pop      = i_rready & o_rvalid;
  assign o_rdata  = mem_q[rbin_q[AW-1:0]];

  always_ff @(posedge i_wclk) begin
    if (push) begin
      mem_q[wbin_q[AW-1:0]] <= i_wdata;
    end
  end

  always_ff @(posedge i_wclk or negedge i_wrst_n) begin
    if (!i_wrst_n) begin
      wbin_q  <= '0;
      wgray_q <= '0;
    end else if (i_wclr) begin
      wbin_q  <= '0;
      wgray_q <= '0;
    end else if (push) begin
      wbin_q  <= wbin_n;
      wgray_q <= wbin_n ^ (wbin_n >> 1);
    end
  end

  always_ff @(posedge i_wclk or negedge i_wrst_n) begin
    if (!i_wrst_n) begin
      rg_m_q <= '0;
      rg_s_q <= '0;
    end else begin
      rg_m_q <= rgray_q;
      rg_s_q <= rg_m_q;
    end
  end

  always_ff @(posedge i_rclk or negedge i_rrst_n) begin
    if (!i_rrst_n) begin
      rbin_q  <= '0;
      rgray_q <= '0;
      wg_m_q  <= '0;
      wg_s_q  <= '0;
    end else begin
      wg_m_q <= wgray_q;
      wg_s_q <= wg_m_q;
      if (pop) begin
        rbin_q  <= rbin_n;
        rgray_q <= rbin_n ^ (rbin_n >> 1);
      end
    end
  end
endmodule

module sfc_frontend (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_sclk,
  input  wire logic              i_cs_n,
  input  wire logic [3:0]        i_io,
  output logic [3:0]             o_io,
  output logic [3:0]             o_io_oe,
  input  wire logic [23:0]       i_status,
  input  wire sfc_pkg::sfc_prot_s i_prot,
  output sfc_pkg::sfc_rd_s       o_rd,
  input  wire logic              i_rd_valid,
  input  wire logic [7:0]        i_rd_data,
  output logic                   o_rd_ready,
  output logic                   o_pgm_valid,
  output logic [7:0]             o_pgm_data,
  output sfc_pkg::sfc_cmd_s      o_cmd,
  output logic                   o_write_latch_flag,
  output logic                   o_dpd
);
  import sfc_pkg::*;

  logic        frm_rst_n;
  logic        frame_q;
  logic        frm_tgl_q;
  sfc_st_e     st_q;
  sfc_st_e     cur_st;
  sfc_st_e     nxt;
  logic [3:0]  pos_q;
  logic [3:0]  cur_pos;
  logic [3:0]  pos_sum;
  logic [1:0]  cnt_q;
  logic [1:0]  cur_cnt;
  logic [2:0]  clk_mod_q;
  logic [7:0]  sh_q;
  logic [7:0]  byte_in;
  logic [2:0]  lw;
  logic        done;
  logic        last;
  logic        fire;
  sfc_op_s     cur_op;
  sfc_op_s     nop;
  logic [7:0]  op_q;
  logic [23:0] addr_q;
  logic [7:0]  rd_op_q;
  logic [23:0] rd_addr_q;
  logic        rd_tgl_q;
  logic [7:0]  pgm_byte_q;
  logic        pg_tgl_q;
  logic        pgm_any_q;
  logic [15:0] srdat_q;
  logic [1:0]  sr_n_q;

  function automatic sfc_st_e phase_after(input sfc_op_s o, input sfc_st_e s);
    if (s == ST_OP && o.addr) begin
      return ST_ADDR;
    end
    if (s <= ST_ADDR && o.mode) begin
      return ST_MODE;
    end
    if (s <= ST_MODE && o.dummy != 2'h0) begin
      return ST_DUMMY;
    end
    if (o.out_w != 3'h0) begin
      return ST_DOUT;
    end
    if (o.din_w != 3'h0) begin
      return ST_DIN;
    end
    return ST_DONE;
  endfunction

  // Frame marker clears with chip select, so the first edge of a frame restarts framing
  assign frm_rst_n = i_rst_n & ~i_cs_n;
  assign cur_op    = sfc_decode(op_q);

  always_ff @(posedge i_sclk or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      frame_q <= 1'b0;
    end else begin
      frame_q <= 1'b1;
    end
  end

  always_comb begin
    cur_st  = frame_q ? st_q : ST_OP;
    cur_pos = frame_q ? pos_q : 4'h0;
    cur_cnt = frame_q ? cnt_q : 2'h0;
    unique case (cur_st)
      ST_ADDR, ST_MODE, ST_DUMMY: lw = cur_op.in_w;
      ST_DIN: lw = cur_op.din_w;
      default: lw = 3'h1;
    endcase
    unique case (lw)
      3'h4: byte_in = {sh_q[3:0], i_io};
      3'h2: byte_in = {sh_q[5:0], i_io[1:0]};
      default: byte_in = {sh_q[6:0], i_io[0]};
    endcase
    pos_sum = cur_pos + {1'b0, lw};
    done    = pos_sum == 4'h8;
    nop     = (cur_st == ST_OP) ? sfc_decode(byte_in) : cur_op;
    last    = 1'b1;
    if (cur_st == ST_ADDR) begin
      last = cur_cnt == 2'h2;
    end
    if (cur_st == ST_DUMMY) begin
      last = (cur_cnt + 2'h1) == nop.dummy;
    end
    nxt  = cur_st;
    fire = 1'b0;
    if (done && last && cur_st < ST_DIN) begin
      nxt  = phase_after(nop, cur_st);
      fire = nop.out_w != 3'h0 && (cur_st == ST_ADDR || (!nop.addr && nxt == ST_DOUT));
    end
  end

  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q      <= ST_OP;
      pos_q     <= 4'h0;
      cnt_q     <= 2'h0;
      clk_mod_q <= 3'h0;
      sh_q      <= 8'h00;
    end else begin
      st_q      <= nxt;
      pos_q     <= done ? 4'h0 : pos_sum;
      sh_q      <= byte_in;
      clk_mod_q <= frame_q ? clk_mod_q + 3'h1 : 3'h1;
      if (done) begin
        cnt_q <= (nxt != cur_st) ? 2'h0 : cur_cnt + 2'h1;
      end else begin
        cnt_q <= cur_cnt;
      end
    end
  end

  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frm_tgl_q  <= 1'b0;
      op_q       <= 8'h00;
      addr_q     <= 24'h000000;
      rd_op_q    <= 8'h00;
      rd_addr_q  <= 24'h000000;
      rd_tgl_q   <= 1'b0;
      pgm_byte_q <= 8'h00;
      pg_tgl_q   <= 1'b0;
      pgm_any_q  <= 1'b0;
      srdat_q    <= 16'h0000;
      sr_n_q     <= 2'h0;
    end else begin
      if (!frame_q) begin
        frm_tgl_q <= ~frm_tgl_q;
        pgm_any_q <= 1'b0;
        sr_n_q    <= 2'h0;
      end
      if (done && cur_st == ST_OP) begin
        op_q <= byte_in;
      end
      if (done && cur_st == ST_ADDR) begin
        addr_q <= {addr_q[15:0], byte_in};
      end
      if (fire) begin
        rd_op_q   <= (cur_st == ST_OP) ? byte_in : op_q;
        rd_addr_q <= (cur_st == ST_ADDR) ? {addr_q[15:0], byte_in} : 24'h000000;
        rd_tgl_q  <= ~rd_tgl_q;
      end
      if (done && cur_st == ST_DIN) begin
        if (op_q == OP_PP || op_q == OP_QPP) begin
          pgm_byte_q <= byte_in;
          pg_tgl_q   <= ~pg_tgl_q;
          pgm_any_q  <= 1'b1;
        end else begin
          srdat_q <= {srdat_q[7:0], byte_in};
          sr_n_q  <= (sr_n_q == 2'h3) ? 2'h3 : sr_n_q + 2'h1;
        end
      end
    end
  end

  // Output side on the falling edge; FIFO read side shares that edge
  logic       sclk_n;
  logic       oe_q;
  logic [7:0] ob_q;
  logic [2:0] opos_q;
  logic       f_rready;
  logic       f_rvalid;
  logic [7:0] f_rdata;
  logic       in_dout;

  assign sclk_n   = ~i_sclk;
  assign in_dout  = frame_q && st_q == ST_DOUT;
  assign f_rready = in_dout && opos_q == 3'h0;

  always_ff @(negedge i_sclk or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      oe_q   <= 1'b0;
      ob_q   <= IDLE_BYTE;
      opos_q <= 3'h0;
    end else if (in_dout) begin
      oe_q   <= 1'b1;
      opos_q <= opos_q + cur_op.out_w;
      if (opos_q == 3'h0) begin
        ob_q <= f_rvalid ? f_rdata : IDLE_BYTE;
      end else begin
        ob_q <= ob_q << cur_op.out_w;
      end
    end else begin
      oe_q <= 1'b0;
    end
  end

  always_comb begin
    unique case (cur_op.out_w)
      3'h4: begin
        o_io    = ob_q[7:4];
        o_io_oe = 4'hf;
      end
      3'h2: begin
        o_io    = {2'b00, ob_q[7:6]};
        o_io_oe = 4'h3;
      end
      default: begin
        o_io    = {2'b00, ob_q[7], 1'b0};
        o_io_oe = 4'h2;
      end
    endcase
    // Gated straight from the pin so release does not wait for a clock edge
    o_io_oe = o_io_oe & {4{oe_q & ~i_cs_n}};
  end

  // Core domain
  logic        cs_m_q;
  logic        cs_s_q;
  logic        cs_p_q;
  logic [2:0]  rd_sy_q;
  logic [2:0]  pg_sy_q;
  logic [1:0]  fr_sy_q;
  logic        fr_seen_q;
  logic        frame_end;
  logic        ok;
  logic        run;
  logic        wel_q;
  logic        vsr_q;
  logic        rst_en_q;
  logic        dpd_q;
  logic        fill_q;
  logic        stat_q;
  logic [1:0]  ssel_q;
  logic        rd_ev;
  logic        pg_ev;
  logic [23:0] rng_lo;
  logic [23:0] rng_hi;
  logic        hit;
  logic        is_pgm;
  logic        pgm_ok;
  logic        pgm_drop;
  logic        er_ok;
  logic        sr_ok;
  logic        srst;
  logic        simple;
  sfc_cmd_e    kind;
  logic [7:0]  stat_byte;
  logic [7:0]  sr1;
  logic        f_wready;
  sfc_op_s     rd_dec;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_m_q  <= 1'b1;
      cs_s_q  <= 1'b1;
      cs_p_q  <= 1'b1;
      rd_sy_q <= 3'h0;
      pg_sy_q <= 3'h0;
      fr_sy_q <= 2'h0;
    end else begin
      cs_m_q  <= i_cs_n;
      cs_s_q  <= cs_m_q;
      cs_p_q  <= cs_s_q;
      rd_sy_q <= {rd_sy_q[1:0], rd_tgl_q};
      pg_sy_q <= {pg_sy_q[1:0], pg_tgl_q};
      fr_sy_q <= {fr_sy_q[0], frm_tgl_q};
    end
  end

  assign rd_ev     = rd_sy_q[2] ^ rd_sy_q[1];
  assign pg_ev     = pg_sy_q[2] ^ pg_sy_q[1];
  assign frame_end = cs_s_q & ~cs_p_q;
  // A frame with no clocks leaves stale link state; the frame toggle screens it out
  assign ok        = frame_end & (fr_sy_q[1] != fr_seen_q);
  assign run       = ok & (clk_mod_q == 3'h0) & (!dpd_q | op_q == OP_RDPD);
  assign simple    = run & st_q == ST_DONE;
  assign rd_dec    = sfc_decode(rd_op_q);

  always_comb begin
    rng_lo = addr_q;
    rng_hi = addr_q;
    kind   = CMD_PGM;
    unique case (op_q)
      OP_PP, OP_QPP: begin
        rng_lo = addr_q & ~PAGE_MASK;
        rng_hi = addr_q | PAGE_MASK;
      end
      OP_SE: begin
        rng_lo = addr_q & ~SECT_MASK;
        rng_hi = addr_q | SECT_MASK;
        kind   = CMD_SE;
      end
      OP_BE: begin
        rng_lo = addr_q & ~BLK_MASK;
        rng_hi = addr_q | BLK_MASK;
        kind   = CMD_BE;
      end
      OP_CE1, OP_CE2: begin
        rng_lo = 24'h000000;
        rng_hi = ARR_TOP;
        kind   = CMD_CE;
      end
      default: kind = CMD_PGM;
    endcase
    hit      = sfc_overlap(i_prot, rng_lo, rng_hi);
    is_pgm   = op_q == OP_PP || op_q == OP_QPP;
    pgm_ok   = run & is_pgm & st_q == ST_DIN & pgm_any_q & wel_q & ~hit;
    pgm_drop = ok & is_pgm & ~pgm_ok;
    er_ok    = simple & kind != CMD_PGM & wel_q & ~hit;
    sr_ok    = run & st_q == ST_DIN & (wel_q | vsr_q) & (sr_n_q == 2'h1 | (op_q == OP_WR_SR1 & sr_n_q == 2'h2))
             & (op_q == OP_WR_SR1 | op_q == OP_WR_SR2 | op_q == OP_WR_SR3);
    srst     = simple & op_q == OP_RST & rst_en_q;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fr_seen_q <= 1'b0;
      wel_q     <= 1'b0;
      vsr_q     <= 1'b0;
      rst_en_q  <= 1'b0;
      dpd_q     <= 1'b0;
    end else if (frame_end) begin
      fr_seen_q <= fr_sy_q[1];
      if (ok) begin
        rst_en_q <= simple & op_q == OP_RST_EN;
        if (srst) begin
          wel_q <= 1'b0;
          vsr_q <= 1'b0;
        end else begin
          if (simple & op_q == OP_SET_WL) begin
            wel_q <= 1'b1;
          end else if ((simple & op_q == OP_CLR_WL) | pgm_ok | er_ok | (sr_ok & ~vsr_q)) begin
            wel_q <= 1'b0;
          end
          if (simple & op_q == OP_VSR_EN) begin
            vsr_q <= 1'b1;
          end else if (sr_ok) begin
            vsr_q <= 1'b0;
          end
        end
        if (op_q == OP_RDPD) begin
          dpd_q <= 1'b0;
        end else if (simple & op_q == OP_DPD) begin
          dpd_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cmd <= '0;
    end else begin
      o_cmd.valid   <= pgm_ok | pgm_drop | er_ok | sr_ok | srst;
      o_cmd.kind    <= srst ? CMD_SRST : sr_ok ? CMD_SR_WR : pgm_drop ? CMD_PGM_DROP : kind;
      o_cmd.addr    <= addr_q;
      o_cmd.sr_data <= srdat_q;
      o_cmd.sr_cnt  <= sr_n_q;
      o_cmd.sr_sel  <= (op_q == OP_WR_SR2) ? 2'h1 : (op_q == OP_WR_SR3) ? 2'h2 : 2'h0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pgm_valid <= 1'b0;
      o_pgm_data  <= 8'h00;
      o_rd        <= '0;
      fill_q      <= 1'b0;
      stat_q      <= 1'b0;
      ssel_q      <= 2'h0;
    end else begin
      // Link byte register holds for at least two serial clocks after the toggle
      o_pgm_valid <= pg_ev & wel_q & ~dpd_q;
      o_pgm_data  <= pgm_byte_q;
      o_rd.start  <= rd_ev & ~rd_dec.stat & (~dpd_q | rd_op_q == OP_RDPD);
      o_rd.op     <= rd_op_q;
      o_rd.addr   <= rd_addr_q;
      if (cs_s_q) begin
        fill_q <= 1'b0;
      end else if (rd_ev) begin
        fill_q <= ~dpd_q | rd_op_q == OP_RDPD;
        stat_q <= rd_dec.stat;
        ssel_q <= (rd_op_q == OP_RD_SR2) ? 2'h1 : (rd_op_q == OP_RD_SR3) ? 2'h2 : 2'h0;
      end
    end
  end

  always_comb begin
    sr1              = i_status[7:0];
    sr1[STAT_WL_BIT] = wel_q;
    unique case (ssel_q)
      2'h1: stat_byte = i_status[15:8];
      2'h2: stat_byte = i_status[23:16];
      default: stat_byte = sr1;
    endcase
  end

  assign o_rd_ready         = fill_q & ~stat_q & f_wready;
  assign o_write_latch_flag = wel_q;
  assign o_dpd              = dpd_q;

  sfc_fifo #(
    .W (FIFO_W),
    .D (FIFO_D)
  ) u_fifo (
    .i_wclk   (i_clk),
    .i_wrst_n (i_rst_n),
    .i_wclr   (cs_s_q),
    .i_wvalid (fill_q & (stat_q | i_rd_valid)),
    .i_wdata  (stat_q ? stat_byte : i_rd_data),
    .o_wready (f_wready),
    .i_rclk   (sclk_n),
    .i_rrst_n (frm_rst_n),
    .i_rready (f_rready),
    .o_rvalid (f_rvalid),
    .o_rdata  (f_rdata)
  );
endmodule

//--- bench/sfc_frontend_checker.sv
// Purpose: Port checks of the front end.
// Assumes: Core clock domain only.
// Notes:   Bound from the bench top.
`timescale 1ns/1ps
module sfc_frontend_checker (
  input wire logic               i_clk,
  input wire logic               i_rst_n,
  input wire logic               i_cs_n,
  input wire logic [3:0]         o_io_oe,
  input wire sfc_pkg::sfc_prot_s i_prot,
  input wire sfc_pkg::sfc_rd_s   o_rd,
  input wire logic               o_rd_ready,
  input wire logic               o_pgm_valid,
  input wire sfc_pkg::sfc_cmd_s  o_cmd,
  input wire logic               o_write_latch_flag
);
  import sfc_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_oe_idle: assert property (i_cs_n |-> o_io_oe == 4'h0) else $error("lanes driven idle");
  a_fill_stop: assert property (i_cs_n [*6] |-> !o_rd_ready) else $error("fill after frame");
  a_cmd_pulse: assert property (o_cmd.valid |=> !o_cmd.valid) else $error("long command");
  a_cmd_framed: assert property (o_cmd.valid |-> i_cs_n && $past(i_cs_n, 2)) else $error("early command");
  a_rd_framed: assert property (o_rd.start |-> !i_cs_n) else $error("late read start");
  a_pgm_latch: assert property (o_pgm_valid |-> o_write_latch_flag) else $error("unlatched byte");
  a_prot_guard: assert property (
    o_cmd.valid && i_prot.en && o_cmd.kind inside {CMD_SE, CMD_BE, CMD_PGM}
    |-> !(o_cmd.addr >= i_prot.lo && o_cmd.addr <= i_prot.hi)) else $error("protected write");
  a_wl_quiet: assert property ($changed(o_write_latch_flag) |-> i_cs_n) else $error("latch moved");
  c_drop: cover property (o_cmd.valid && o_cmd.kind == CMD_PGM_DROP);
  c_quad: cover property (o_io_oe == 4'hf);
  c_start: cover property (o_rd.start);
endmodule

//--- bench/sfc_host.sv
// Purpose: Host model on the serial link.
// Assumes: Mode 0, clock only inside frames.
// Notes:   Released lanes show inverted data.
`timescale 1ns/1ps
module sfc_host (
  output logic            o_sclk,
  output logic            o_cs_n,
  output logic [3:0]      o_io,
  input  wire logic [3:0] i_io
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'h0;
  end

  // Offset keeps link edges clear of core edges
  task automatic open_f();
    #1;
    o_cs_n = 1'b0;
    #20;
  endtask

  task automatic tx(input logic [7:0] v, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      o_io[0] = v[i];
      #32 o_sclk = 1'b1;
      #32 o_sclk = 1'b0;
    end
  endtask

  task automatic rx(input int w, output logic [7:0] v);
    v = 8'h00;
    for (int i = 0; i < 8 / w; i++) begin
      #32;
      v = (w == 1) ? {v[6:0], i_io[1]} : (w == 2) ? {v[5:0], i_io[1:0]} : {v[3:0], i_io};
      o_sclk = 1'b1;
      #32 o_sclk = 1'b0;
    end
  endtask

  task automatic close_f();
    #20;
    o_cs_n = 1'b1;
    o_io = ~o_io;
    #199;
  endtask
endmodule

//--- bench/sfc_frontend_tb.sv
// Purpose: Bench for the front end.
// Assumes: Host model drives the link.
// Notes:   Stream valid toggles to leave gaps.
`timescale 1ns/1ps
module sfc_frontend_tb;
  import sfc_pkg::*;
  logic        i_clk, i_rst_n, i_sclk, i_cs_n, i_rd_valid, o_rd_ready, o_pgm_valid, o_write_latch_flag, o_dpd;
  logic [3:0]  i_io, o_io, o_io_oe;
  logic [7:0]  i_rd_data, o_pgm_data, last_pgm, b;
  logic [23:0] i_status;
  sfc_prot_s   i_prot;
  sfc_rd_s     o_rd, last_rd;
  sfc_cmd_s    o_cmd, last_cmd;
  int          error_cnt, n_checks, ncmd, cyc;

  sfc_frontend dut_u (.i_clk, .i_rst_n, .i_sclk, .i_cs_n, .i_io, .o_io, .o_io_oe, .i_status, .i_prot, .o_rd,
    .i_rd_valid, .i_rd_data, .o_rd_ready, .o_pgm_valid, .o_pgm_data, .o_cmd, .o_write_latch_flag, .o_dpd);
  // Undriven lanes read back inverted, so a missing or late enable corrupts the data seen
  sfc_host host_u (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_io(i_io), .i_io(o_io ^ ~o_io_oe));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    i_rd_valid <= ~i_rd_valid;
    if (i_cs_n)
      i_rd_data <= 8'h3c;
    else if (i_rd_valid && o_rd_ready)
      i_rd_data <= i_rd_data + 8'h01;
    if (o_cmd.valid) begin
      ncmd <= ncmd + 1;
      last_cmd <= o_cmd;
    end
    if (o_pgm_valid)
      last_pgm <= o_pgm_data;
    if (o_rd.start)
      last_rd <= o_rd;
    if (cyc == 30000) begin
      error_cnt = error_cnt + 1;
      conclude();
    end
  end

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic go(input logic [7:0] op, input logic [31:0] v, input int nb, input int part);
    host_u.open_f();
    host_u.tx(op, 8);
    for (int i = 0; i < nb; i++)
      host_u.tx(v[31 - 8 * i -: 8], 8);
    host_u.tx(8'h5a, part);
    host_u.close_f();
  endtask

  task automatic t_latch();
    go(OP_SET_WL, 0, 0, 0);
    chk(24'(o_write_latch_flag), 24'h1);
    go(OP_CLR_WL, 0, 0, 0);
    chk(24'(o_write_latch_flag), 24'h0);
    go(OP_SET_WL, 0, 0, 7);
    chk(24'(o_write_latch_flag), 24'h0);
    go(OP_DPD, 0, 0, 3);
    chk(24'(o_dpd), 24'h0);
    go(OP_DPD, 0, 0, 0);
    chk(24'(o_dpd), 24'h1);
    go(OP_RDPD, 0, 0, 0);
    chk(24'(o_dpd), 24'h0);
    go(OP_VSR_EN, 0, 0, 0);
    go(OP_WR_SR1, 32'hab000000, 1, 0);
    chk(24'({last_cmd.kind, last_cmd.sr_data}), 24'({CMD_SR_WR, 16'h00ab}));
    chk(24'({last_cmd.sr_sel, last_cmd.sr_cnt}), 24'h1);
    go(OP_RST_EN, 0, 0, 0);
    go(OP_RST, 0, 0, 0);
    chk(24'(last_cmd.kind), 24'(CMD_SRST));
    $display("t_latch done");
  endtask

  task automatic t_prog();
    int n0;
    go(OP_SET_WL, 0, 0, 0);
    go(OP_PP, 32'h000100a5, 4, 3);
    chk(24'({last_pgm, last_cmd.kind, o_write_latch_flag}), 24'({8'ha5, CMD_PGM_DROP, 1'b1}));
    @(posedge i_clk);
    i_prot <= '{1'b1, 24'h000000, 24'h000fff};
    n0 = ncmd;
    go(OP_SE, 32'h00080000, 3, 0);
    chk(24'(ncmd - n0), 24'h0);
    chk(24'(o_write_latch_flag), 24'h1);
    go(OP_SE, 32'h00100000, 3, 0);
    chk(24'({last_cmd.kind, o_write_latch_flag}), 24'({CMD_SE, 1'b0}));
    chk(last_cmd.addr, 24'h001000);
    go(OP_SET_WL, 0, 0, 0);
    n0 = ncmd;
    go(OP_CE2, 0, 0, 0);
    chk(24'(ncmd - n0), 24'h0);
    go(OP_BE, 32'h01000000, 3, 0);
    chk(24'({last_cmd.kind, o_write_latch_flag}), 24'({CMD_BE, 1'b0}));
    chk(last_cmd.addr, 24'h010000);
    $display("t_prog done");
  endtask

  task automatic t_read();
    logic [7:0] ops [3] = '{OP_FAST, OP_DOUT, OP_QOUT};
    for (int i = 0; i < 3; i++) begin
      host_u.open_f();
      host_u.tx(ops[i], 8);
      for (int j = 0; j < 4; j++)
        host_u.tx(8'(32'h12345600 >> (24 - 8 * j)), 8);
      for (int j = 0; j < 3; j++) begin
        host_u.rx(1 << i, b);
        chk(24'(b), 24'(8'h3c + 8'(j)));
      end
      chk(24'(o_io_oe), 24'(i == 0 ? 4'h2 : i == 1 ? 4'h3 : 4'hf));
      host_u.close_f();
      chk(last_rd.addr, 24'h123456);
      chk(24'(last_rd.op), 24'(ops[i]));
    end
    $display("t_read done");
  endtask

  task automatic t_stat();
    logic [7:0] ops [3] = '{OP_RD_SR1, OP_RD_SR2, OP_RD_SR3};
    @(posedge i_clk);
    i_status <= 24'hc35a7e;
    for (int i = 0; i < 3; i++) begin
      host_u.open_f();
      host_u.tx(ops[i], 8);
      host_u.rx(1, b);
      repeat (2) begin
        host_u.rx(1, b);
        chk(24'(b), 24'(i == 0 ? 8'h7c : i == 1 ? 8'h5a : 8'hc3));
      end
      host_u.close_f();
    end
    $display("t_stat done");
  endtask

  initial begin
    i_rst_n = 1'b0;
    i_rd_valid = 1'b0;
    i_rd_data = 8'h3c;
    i_status = 24'h0;
    i_prot = '0;
    error_cnt = 0;
    n_checks = 0;
    ncmd = 0;
    cyc = 0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_latch();
    t_prog();
    t_read();
    t_stat();
    conclude();
  end
endmodule

bind sfc_frontend sfc_frontend_checker chk_u (.i_clk, .i_rst_n, .i_cs_n, .o_io_oe, .i_prot, .o_rd, .o_rd_ready,
  .o_pgm_valid, .o_cmd, .o_write_latch_flag);
